// ==== rtl/stack_irq_ctrl.sv ====
`timescale 1ns/100ps
// Notes on behaviour
// [RULE1] registers 26..31 pair into three 16-bit data pointers
// [RULE2] pointers support displacement, post-increment and pre-decrement forms
// [RULE3] stack grows downward; pushes lower the pointer
// [RULE4] single byte push subtracts one, pop adds one
// [RULE5] call and interrupt subtract two; returns add two
// [RULE6] pointer held as high and low 8-bit io registers
// [RULE7] software loads the pointer above 0x60 before calls or interrupts
// [RULE8] logic runs straight on the core clock, no division
// [RULE9] next fetch overlaps current execute, one instruction per cycle
// [RULE10] two operands read, operated and written back in one cycle
// [RULE11] interrupt taken only with both its enable and global enable
// [RULE12] lower vector number ranks higher; external irq zero first
// [RULE13] entry clears global enable; handler may set it for nesting
// [RULE14] interrupt exit instruction sets global enable
// [RULE15] latched flag cleared by hardware when vectored
// [RULE16] writing one clears a flag, zero leaves it
// [RULE17] flag latched while disabled, held until enabled or cleared
// [RULE18] pending flags served one by one in priority order
// [RULE19] level sources request only while their condition stands
// [RULE20] after interrupt exit one instruction runs before next service
// [RULE21] flags register neither saved nor restored by entry or exit
// [RULE22] disable instruction blocks any interrupt in the same cycle
// [RULE23] reset loads the pointer with the last sram address
module stack_irq_ctrl #(
  parameter int n_irq = 8,
  parameter logic [n_irq-1:0] level_mask = 8'h00
) (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic io_wr,
  input wire logic io_rd,
  input wire logic [5:0] io_addr,
  input wire logic [7:0] io_wdata,
  output logic [7:0] io_rdata,
  input wire logic [2:0] sp_op,
  input wire logic instr_done,
  input wire logic set_gie,
  input wire logic clr_gie,
  input wire logic [n_irq-1:0] irq_src,
  output logic [15:0] stack_addr,
  output logic irq_take,
  output logic [2:0] irq_vector,
  output logic [7:0] cpu_flags_register,
  input wire logic [1:0] ptr_sel,
  input wire logic [1:0] ptr_mode,
  input wire logic [5:0] ptr_disp,
  input wire logic ptr_req,
  output logic [15:0] ptr_addr,
  input wire logic [4:0] rd_a_idx,
  input wire logic [4:0] rd_b_idx,
  output logic [7:0] rd_a_data,
  output logic [7:0] rd_b_data,
  input wire logic gpr_wr,
  input wire logic [4:0] gpr_idx,
  input wire logic [7:0] gpr_data
);
  logic [15:0] sp_r;
  logic [15:0] sp_nxt;
  logic [7:0] flags_r;
  logic [n_irq-1:0] pend_r;
  logic [n_irq-1:0] en_r;
  logic [n_irq-1:0] s1_r;
  logic [n_irq-1:0] s2_r;
  logic [n_irq-1:0] s3_r;
  logic [n_irq-1:0] req;
  logic [n_irq-1:0] take_vec;
  logic [2:0] win;
  logic any_req;
  logic hold_r;
  logic take;
  logic [47:0] ptr_all;
  logic [15:0] ptr_cur;
  logic [15:0] ptr_new;
  logic ptr_wr;
  logic [n_irq-1:0] filt_r;
  logic [n_irq-1:0] rise;
  logic wr_sp_lo;
  logic wr_sp_hi;
  logic wr_flags;
  logic wr_pend;
  logic wr_enable;
  logic exit_op;
  logic gie;
  // ---------------------------------------------------------------
  // register file and pointer pairs
  // ---------------------------------------------------------------
  pointer_file #(.n_regs(32)) u_regs (
    .mclk(mclk),
    .rst_b(rst_b),
    .rd_a_idx(rd_a_idx),
    .rd_b_idx(rd_b_idx),
    .rd_a_data(rd_a_data), // RULE10
    .rd_b_data(rd_b_data),
    .wr_en(gpr_wr),
    .wr_idx(gpr_idx),
    .wr_data(gpr_data),
    .ptr_wr_en(ptr_wr),
    .ptr_wr_sel(ptr_sel),
    .ptr_wr_data(ptr_new),
    .ptr_all(ptr_all)
  );
  always_comb begin
    ptr_cur = ptr_all[ptr_sel*16 +: 16]; // RULE1
    ptr_new = ptr_cur;
    ptr_wr = 1'b0;
    case (stack_irq_pkg::ptr_mode_t'(ptr_mode)) // RULE2
      stack_irq_pkg::mode_postinc: begin
        ptr_new = ptr_cur + 16'h0001;
        ptr_wr = ptr_req;
      end
      stack_irq_pkg::mode_predec: begin
        ptr_new = ptr_cur - 16'h0001;
        ptr_wr = ptr_req;
      end
      default: begin
        ptr_new = ptr_cur;
      end
    endcase
  end
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      ptr_addr <= 16'h0000;
    end else if (ptr_req) begin
      case (stack_irq_pkg::ptr_mode_t'(ptr_mode))
        stack_irq_pkg::mode_disp: ptr_addr <= ptr_cur + {10'h000, ptr_disp}; // RULE2
        stack_irq_pkg::mode_predec: ptr_addr <= ptr_new;
        default: ptr_addr <= ptr_cur;
      endcase
    end
  end
  // ---------------------------------------------------------------
  // source synchronisers
  // ---------------------------------------------------------------
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      s1_r <= '0;
      s2_r <= '0;
      s3_r <= '0;
    end else begin
      s1_r <= irq_src;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end
  // ---------------------------------------------------------------
  // edge filter, a change counts once stages two and three agree
  // ---------------------------------------------------------------
  genvar g;
  for (g = 0; g < n_irq; g++) begin : g_filt
    always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
        filt_r[g] <= 1'b0;
      end else if (s2_r[g] == s3_r[g]) begin
        filt_r[g] <= s3_r[g];
      end
    end
    assign rise[g] = s2_r[g] & s3_r[g] & !filt_r[g];
  end
  // ---------------------------------------------------------------
  // priority pick
  // ---------------------------------------------------------------
  for (g = 0; g < n_irq; g++) begin : g_req
    assign req[g] = level_mask[g] ? filt_r[g] & en_r[g] // RULE19
                                  : pend_r[g] & en_r[g]; // RULE11
  end
  always_comb begin
    win = 3'd0;
    any_req = 1'b0;
    for (int i = n_irq - 1; i >= 0; i--) begin
      if (req[i]) begin
        win = i[2:0]; // RULE12
        any_req = 1'b1;
      end
    end
  end
  // ---------------------------------------------------------------
  // take decision
  // ---------------------------------------------------------------
  // global enable taken from the register, a same-cycle clear vetoes
  assign gie = flags_r[stack_irq_pkg::gie_bit];
  always_comb begin
    take = any_req & gie & instr_done; // RULE11
    if (clr_gie) take = 1'b0; // RULE22
    if (hold_r) take = 1'b0; // RULE20
  end
  always_comb begin
    take_vec = '0;
    if (take) begin
      take_vec[win] = 1'b1;
    end
  end
  // ---------------------------------------------------------------
  // io write decode
  // ---------------------------------------------------------------
  assign wr_sp_lo = io_wr && io_addr == stack_irq_pkg::sp_low_offset;
  assign wr_sp_hi = io_wr && io_addr == stack_irq_pkg::sp_high_offset;
  assign wr_flags = io_wr && io_addr == stack_irq_pkg::flags_offset;
  assign wr_pend = io_wr && io_addr == stack_irq_pkg::flag_reg_offset;
  assign wr_enable = io_wr && io_addr == stack_irq_pkg::enable_reg_offset;
  assign exit_op = sp_op == 3'(stack_irq_pkg::sp_irq_exit);
  // ---------------------------------------------------------------
  // flags, pending and enable registers
  // ---------------------------------------------------------------
  for (g = 0; g < n_irq; g++) begin : g_pend
    always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
        pend_r[g] <= 1'b0;
      end else if (!level_mask[g] && rise[g]) begin
        pend_r[g] <= 1'b1; // RULE17
      end else if (take_vec[g]) begin
        pend_r[g] <= 1'b0; // RULE15
      end else if (wr_pend && io_wdata[g]) begin
        pend_r[g] <= 1'b0; // RULE16
      end
    end
  end
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      en_r <= '0;
    end else if (wr_enable) begin
      en_r <= io_wdata[n_irq-1:0];
    end
  end
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      flags_r <= stack_irq_pkg::flags_reset;
    end else begin
      if (wr_flags) begin
        flags_r <= io_wdata;
      end
      if (set_gie || exit_op) begin
        flags_r[stack_irq_pkg::gie_bit] <= 1'b1; // RULE14
      end
      if (clr_gie || take) begin
        flags_r[stack_irq_pkg::gie_bit] <= 1'b0; // RULE13
      end
    end
  end
  // other flag bits untouched by entry and exit
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      hold_r <= 1'b0;
    end else if (exit_op || set_gie) begin
      hold_r <= 1'b1; // RULE20
    end else if (instr_done) begin
      hold_r <= 1'b0; // RULE18
    end
  end
  // ---------------------------------------------------------------
  // stack pointer
  // ---------------------------------------------------------------
  always_comb begin
    sp_nxt = sp_r;
    case (stack_irq_pkg::sp_op_t'(sp_op))
      stack_irq_pkg::sp_push: sp_nxt = sp_r - 16'h0001; // RULE4
      stack_irq_pkg::sp_pop: sp_nxt = sp_r + 16'h0001; // RULE4
      stack_irq_pkg::sp_call: sp_nxt = sp_r - 16'h0002; // RULE5
      stack_irq_pkg::sp_irq: sp_nxt = sp_r - 16'h0002; // RULE3
      stack_irq_pkg::sp_sub_exit: sp_nxt = sp_r + 16'h0002; // RULE5
      stack_irq_pkg::sp_irq_exit: sp_nxt = sp_r + 16'h0002; // RULE5
      default: sp_nxt = sp_r;
    endcase
    if (take) sp_nxt = sp_r - 16'h0002; // RULE5
    if (wr_sp_lo) sp_nxt[7:0] = io_wdata; // RULE6
    if (wr_sp_hi) sp_nxt[15:8] = io_wdata; // RULE6
  end
  always_ff @(posedge mclk or negedge rst_b) begin // RULE8
    if (!rst_b) begin
      sp_r <= stack_irq_pkg::sram_end; // RULE23
    end else begin
      sp_r <= sp_nxt;
    end
  end
  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      stack_addr <= stack_irq_pkg::sram_end;
      irq_take <= 1'b0;
      irq_vector <= 3'd0;
      cpu_flags_register <= stack_irq_pkg::flags_reset;
      io_rdata <= 8'h00;
    end else begin
      stack_addr <= sp_nxt;
      irq_take <= take; // RULE9
      if (take) irq_vector <= win;
      cpu_flags_register <= flags_r; // RULE21
      io_rdata <= 8'h00;
      if (io_rd) begin
        case (io_addr)
          stack_irq_pkg::sp_low_offset: io_rdata <= sp_r[7:0];
          stack_irq_pkg::sp_high_offset: io_rdata <= sp_r[15:8];
          stack_irq_pkg::flags_offset: io_rdata <= flags_r;
          stack_irq_pkg::flag_reg_offset: io_rdata <= 8'(pend_r);
          stack_irq_pkg::enable_reg_offset: io_rdata <= 8'(en_r);
          default: io_rdata <= 8'h00;
        endcase
      end
    end
  end
endmodule

// ==== rtl/stack_irq_pkg.sv ====
package stack_irq_pkg;
  // ---------------------------------------------------------------
  // io space offsets of the stack pointer bytes, flags, pending flag and enable registers
  // ---------------------------------------------------------------
  localparam logic [5:0] sp_low_offset = 6'h3d;
  localparam logic [5:0] sp_high_offset = 6'h3e;
  localparam logic [5:0] flags_offset = 6'h3f;
  localparam logic [5:0] flag_reg_offset = 6'h3c;
  localparam logic [5:0] enable_reg_offset = 6'h3b;
  // ---------------------------------------------------------------
  // field positions and reset values
  // ---------------------------------------------------------------
  localparam int gie_bit = 7;
  localparam logic [15:0] sram_end = 16'h02ff;
  localparam logic [7:0] flags_reset = 8'h00;
  localparam logic [15:0] sp_min = 16'h0060;
  // ---------------------------------------------------------------
  // pointer selects, addressing forms and stack operations
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {ptr_x, ptr_y, ptr_z} ptr_sel_t;
  typedef enum logic [1:0] {mode_plain, mode_disp, mode_postinc, mode_predec} ptr_mode_t;
  typedef enum logic [2:0] {
    sp_none, sp_push, sp_pop, sp_call, sp_sub_exit, sp_irq, sp_irq_exit
  } sp_op_t;
endpackage

// ==== rtl/pointer_file.sv ====
`timescale 1ns/100ps
module pointer_file #(
  parameter int n_regs = 32
) (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic [4:0] rd_a_idx,
  input wire logic [4:0] rd_b_idx,
  output logic [7:0] rd_a_data,
  output logic [7:0] rd_b_data,
  input wire logic wr_en,
  input wire logic [4:0] wr_idx,
  input wire logic [7:0] wr_data,
  input wire logic ptr_wr_en,
  input wire logic [1:0] ptr_wr_sel,
  input wire logic [15:0] ptr_wr_data,
  output logic [47:0] ptr_all
);
  logic [7:0] mem [n_regs];
  // ---------------------------------------------------------------
  // storage, ptr update has priority over byte write
  // ---------------------------------------------------------------
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      for (int i = 0; i < n_regs; i++) mem[i] <= 8'h00;
    end else begin
      if (wr_en) begin
        mem[wr_idx] <= wr_data;
      end
      if (ptr_wr_en) begin
        mem[5'd26 + {ptr_wr_sel, 1'b0}] <= ptr_wr_data[7:0];
        mem[5'd27 + {ptr_wr_sel, 1'b0}] <= ptr_wr_data[15:8];
      end
    end
  end
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      rd_a_data <= 8'h00;
      rd_b_data <= 8'h00;
    end else begin
      rd_a_data <= mem[rd_a_idx];
      rd_b_data <= mem[rd_b_idx];
    end
  end
  genvar g;
  for (g = 0; g < 6; g++) begin : g_ptr
    assign ptr_all[g*8 +: 8] = mem[26 + g];
  end
endmodule

// ==== testbench/sic_chk.sv ====
`timescale 1ns/100ps
// ----
// stack and interrupt checks
// ----
module sic_chk (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic io_wr,
  input wire logic instr_done,
  input wire logic clr_gie,
  input wire logic [2:0] sp_op,
  input wire logic [15:0] stack_addr,
  input wire logic irq_take,
  input wire logic [7:0] cpu_flags_register
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_b);
  logic q;
  assign q = !io_wr && !instr_done;
  push_dec_a: assert property (q && sp_op == 3'h1 |=>
    stack_addr == $past(stack_addr) - 16'h1) else $error("push step");
  pop_inc_a: assert property (q && sp_op == 3'h2 |=>
    stack_addr == $past(stack_addr) + 16'h1) else $error("pop step");
  call_dec_a: assert property (q && sp_op == 3'h3 |=>
    stack_addr == $past(stack_addr) - 16'h2) else $error("call step");
  ret_inc_a: assert property (q && (sp_op == 3'h4 || sp_op == 3'h6) |=>
    stack_addr == $past(stack_addr) + 16'h2) else $error("return step");
  take_gate_a: assert property (irq_take |->
    cpu_flags_register[7] && !$past(clr_gie)) else $error("take gated");
  take_gie_a: assert property (irq_take |=>
    !cpu_flags_register[7]) else $error("take gie");
  take_sp_a: assert property (irq_take |->
    stack_addr == $past(stack_addr) - 16'h2) else $error("take step");
  interrupt_exit_instruction_gie_a: assert property (q && sp_op == 3'h6 && !clr_gie |-> ##2
    cpu_flags_register[7]) else $error("exit gie");
  cover property (irq_take);
  cover property (sp_op == 3'h6);
  cover property (clr_gie && instr_done);
endmodule
bind stack_irq_ctrl sic_chk u_chk (.*);

// ==== testbench/irq_src_model.sv ====
`timescale 1ns/100ps
// ----
// interrupt source pins
// ----
module irq_src_model (
  input wire logic mclk,
  input wire logic [7:0] fire,
  output logic [7:0] irq_src
);
  initial irq_src = 8'h00;
  always @(posedge mclk) irq_src <= #1 fire;
endmodule

// ==== testbench/cpu_stack_and_interrupt_control_test.sv ====
`timescale 1ns/100ps
module cpu_stack_and_interrupt_control_test;
  // ----
  // stimulus and dut
  // ----
  logic mclk = 1'b0, rst_b = 1'b0, io_wr = 1'b0, io_rd = 1'b0, instr_done = 1'b0;
  logic set_gie = 1'b0, clr_gie = 1'b0, ptr_req = 1'b0, gpr_wr = 1'b0, irq_take;
  logic [5:0] io_addr = 6'h00, ptr_disp = 6'h00;
  logic [7:0] io_wdata = 8'h00, gpr_data = 8'h00, fire = 8'h00;
  logic [7:0] io_rdata, cpu_flags_register, rd_a_data, rd_b_data, irq_src;
  logic [4:0] rd_a_idx = 5'h00, rd_b_idx = 5'h00, gpr_idx = 5'h00;
  logic [2:0] sp_op = 3'h0, irq_vector;
  logic [1:0] ptr_sel = 2'h0, ptr_mode = 2'h0;
  logic [15:0] stack_addr, ptr_addr;
  int fails = 0, tests_run = 0;
  always #12.5 mclk = ~mclk;
  irq_src_model u_src (.mclk(mclk), .fire(fire), .irq_src(irq_src));
  stack_irq_ctrl u_dut (
    .mclk(mclk),
    .rst_b(rst_b),
    .io_wr(io_wr),
    .io_rd(io_rd),
    .io_addr(io_addr),
    .io_wdata(io_wdata),
    .io_rdata(io_rdata),
    .sp_op(sp_op),
    .instr_done(instr_done),
    .set_gie(set_gie),
    .clr_gie(clr_gie),
    .irq_src(irq_src),
    .stack_addr(stack_addr),
    .irq_take(irq_take),
    .irq_vector(irq_vector),
    .cpu_flags_register(cpu_flags_register),
    .ptr_sel(ptr_sel),
    .ptr_mode(ptr_mode),
    .ptr_disp(ptr_disp),
    .ptr_req(ptr_req),
    .ptr_addr(ptr_addr),
    .rd_a_idx(rd_a_idx),
    .rd_b_idx(rd_b_idx),
    .rd_a_data(rd_a_data),
    .rd_b_data(rd_b_data),
    .gpr_wr(gpr_wr),
    .gpr_idx(gpr_idx),
    .gpr_data(gpr_data)
  );
  task automatic close_out;
    if (fails == 0 && tests_run > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  task automatic chk(input string what, input logic [15:0] e, input logic [15:0] g);
    tests_run++;
    if (g !== e) begin
      fails++;
      $display("[ERR] %s exp %h got %h", what, e, g);
    end
  endtask
  task automatic io(input logic wr, input logic [5:0] a, input logic [7:0] d);
    io_wr = wr;
    io_rd = !wr;
    io_addr = a;
    io_wdata = d;
    cyc(1);
    if (!wr) chk("io_rdata", {8'h00, d}, {8'h00, io_rdata});
    io_wr = 1'b0;
    io_rd = 1'b0;
    cyc(1);
  endtask
  task automatic spop(input logic [2:0] op, input logic [15:0] e);
    sp_op = op;
    cyc(1);
    chk("stack_addr", e, stack_addr);
  endtask
  task automatic take(input logic [2:0] v);
    instr_done = 1'b1;
    for (int i = 0; i < 6 && irq_take !== 1'b1; i++) cyc(1);
    instr_done = 1'b0;
    chk("irq_take", 16'h0001, {15'h0, irq_take});
    if (irq_take !== 1'b1) close_out();
    chk("irq_vector", {13'h0, v}, {13'h0, irq_vector});
  endtask
  task automatic gw(input logic [4:0] i, input logic [7:0] d);
    gpr_wr = 1'b1;
    gpr_idx = i;
    gpr_data = d;
    cyc(1);
    gpr_wr = 1'b0;
    cyc(1);
  endtask
  task automatic ptr(input logic [1:0] s, input logic [1:0] m, input logic [5:0] d,
                     input logic [15:0] e);
    ptr_req = 1'b1;
    ptr_sel = s;
    ptr_mode = m;
    ptr_disp = d;
    cyc(1);
    chk("ptr_addr", e, ptr_addr);
  endtask
  task automatic t_stack;
    chk("stack_addr", stack_irq_pkg::sram_end, stack_addr);
    io(1'b0, 6'h3e, stack_irq_pkg::sram_end[15:8]);
    io(1'b0, 6'h3d, stack_irq_pkg::sram_end[7:0]);
    io(1'b0, 6'h00, 8'h00);
    io(1'b1, 6'h3d, 8'h80);
    io(1'b1, 6'h3e, 8'h01);
    spop(3'h1, 16'h017f);
    spop(3'h1, 16'h017e);
    spop(3'h2, 16'h017f);
    spop(3'h3, 16'h017d);
    spop(3'h4, 16'h017f);
    spop(3'h5, 16'h017d);
    spop(3'h4, 16'h017f);
    sp_op = 3'h0;
    io(1'b0, 6'h3d, 8'h7f);
  endtask
  task automatic t_irq;
    io(1'b1, 6'h3b, 8'h00);
    fire = 8'h03;
    cyc(2);
    fire = 8'h00;
    cyc(6);
    io(1'b0, 6'h3c, 8'h03);
    io(1'b1, 6'h3b, 8'h03);
    io(1'b1, 6'h3f, 8'h05);
    set_gie = 1'b1;
    cyc(1);
    set_gie = 1'b0;
    take(3'h0);
    cyc(1);
    chk("flags", 16'h0005, cpu_flags_register);
    chk("stack_addr", 16'h017d, stack_addr);
    io(1'b0, 6'h3c, 8'h02);
    spop(3'h6, 16'h017f);
    sp_op = 3'h0;
    cyc(1);
    chk("flags", 16'h0085, cpu_flags_register);
    instr_done = 1'b1;
    cyc(1);
    instr_done = 1'b0;
    chk("irq_take", 16'h0000, {15'h0, irq_take});
    take(3'h1);
    spop(3'h6, 16'h017f);
    sp_op = 3'h0;
  endtask
  task automatic t_cli;
    instr_done = 1'b1;
    cyc(1);
    instr_done = 1'b0;
    fire = 8'h02;
    cyc(2);
    fire = 8'h00;
    cyc(6);
    instr_done = 1'b1;
    clr_gie = 1'b1;
    cyc(1);
    instr_done = 1'b0;
    clr_gie = 1'b0;
    repeat (3) begin
      chk("irq_take", 16'h0000, {15'h0, irq_take});
      cyc(1);
    end
    chk("flags", 16'h0005, cpu_flags_register);
    io(1'b1, 6'h3c, 8'h01);
    io(1'b0, 6'h3c, 8'h02);
    io(1'b1, 6'h3c, 8'h02);
    io(1'b0, 6'h3c, 8'h00);
  endtask
  task automatic t_ptr;
    gw(5'h1a, 8'h34);
    gw(5'h1b, 8'h12);
    ptr(2'h0, 2'h2, 6'h00, 16'h1234);
    ptr(2'h0, 2'h0, 6'h00, 16'h1235);
    ptr(2'h0, 2'h3, 6'h00, 16'h1234);
    ptr_req = 1'b0;
    gw(5'h1d, 8'h02);
    ptr(2'h1, 2'h1, 6'h3f, 16'h023f);
    ptr_req = 1'b0;
    rd_a_idx = 5'h1a;
    rd_b_idx = 5'h1b;
    cyc(1);
    chk("rd_a_data", 16'h0034, {8'h00, rd_a_data});
    chk("rd_b_data", 16'h0012, {8'h00, rd_b_data});
  endtask
  initial begin
    cyc(2);
    rst_b = 1'b1;
    t_stack();
    t_irq();
    t_cli();
    t_ptr();
    close_out();
  end
endmodule
